/* design/rpw_pkg.sv */
// constants for the ring phy path and insertion watchdog
package rpw_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WDCOUNT = 8'h08;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int unsigned CTRL_PHANTOM_EN = 0;
	localparam int unsigned CTRL_CLR_EXPIRED = 1;
	localparam int unsigned ST_LOOPBACK = 0;
	localparam int unsigned ST_REPEAT = 1;
	localparam int unsigned ST_PHANTOM = 2;
	localparam int unsigned ST_EXPIRED = 3;
	localparam int unsigned ST_FAULT_A = 4;
	localparam int unsigned ST_FAULT_B = 5;
	localparam int unsigned ST_SPEED4 = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned WDT_TIMEOUT_US = 21_000;
	localparam int unsigned WDT_CYCLES = WDT_TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam int unsigned WDT_CNT_W = 18;
	localparam int unsigned PHASE_W = 16;
	localparam logic [15:0] INC_16M = 16'h4000;
	localparam logic [15:0] INC_4M = 16'h1000;
	localparam int unsigned LOOP1_SHIFT = 2;
	localparam int unsigned LOOP1_FSHIFT = 5;
	localparam int unsigned LOOP2_SHIFT = 4;
	localparam logic signed [15:0] FREQ_LIM = 16'sh0400;
	localparam int unsigned DIV_W = 4;
	localparam int unsigned DIV_FAST_BIT = 1;
	localparam int unsigned DIV_REF_BIT = 3;
	localparam int unsigned PIN_W = 12;
	localparam logic [11:0] PIN_RESET = 12'h0b0;
endpackage : rpw_pkg

/* design/rpw_pin_sync.sv */
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rpw_pin_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] d_async,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, q_q, q_d;

	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
		begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			q_q <= RESET_VAL;
		end
		else
		begin
			s1_q <= d_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q <= q_d;
		end
	end

	assign q = q_q;
endmodule : rpw_pin_sync
`default_nettype wire

/* design/rpw_top.sv */
// ring phy path select, digital clock recovery, phantom drive and watchdog
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rpw_top #(
	parameter int unsigned WDT_CYCLES = rpw_pkg::WDT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic line_in_p,
	input wire logic line_in_n,
	input wire logic tx_data_in_p,
	input wire logic tx_data_in_n,
	input wire logic loopback_select_n,
	input wire logic repeat_select_n,
	input wire logic speed_select,
	input wire logic insert_request_n,
	input wire logic load_high_a,
	input wire logic load_low_a,
	input wire logic load_high_b,
	input wire logic load_low_b,
	output logic line_out_p,
	output logic line_out_n,
	output logic recovered_data,
	output logic recovered_clock,
	output logic ring_ref_clock,
	output logic fixed_fast_clock,
	output logic phantom_out_a,
	output logic phantom_out_b,
	output logic wire_fault_n
);
	logic [rpw_pkg::PIN_W-1:0] pins_s;
	logic rx_line_s, rx_line_n_s, tx_s, tx_n_s, loop_n_s, rep_n_s, speed_s, ins_n_s;
	logic hi_a_s, lo_a_s, hi_b_s, lo_b_s;

	rpw_pin_sync #(
		.WIDTH(rpw_pkg::PIN_W),
		.RESET_VAL(rpw_pkg::PIN_RESET)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d_async({load_low_b, load_high_b, load_low_a, load_high_a, insert_request_n,
			speed_select, repeat_select_n, loopback_select_n, tx_data_in_n, tx_data_in_p,
			line_in_n, line_in_p}),
		.q(pins_s)
	);

	assign {lo_b_s, hi_b_s, lo_a_s, hi_a_s, ins_n_s, speed_s, rep_n_s, loop_n_s,
		tx_n_s, tx_s, rx_line_n_s, rx_line_s} = pins_s;

	// differential decode; an undriven pair holds the last bit
	function automatic logic diff_bit(input logic p, input logic n, input logic prev);
		diff_bit = (p != n) ? p : prev;
	endfunction : diff_bit

	// fixed-gain loop correction
	function automatic logic [15:0] loop_corr(input logic [15:0] err, input int unsigned sh);
		loop_corr = 16'($signed(err) >>> sh);
	endfunction : loop_corr

	// path select
	logic loop_mode, rep_mode;
	assign loop_mode = ~loop_n_s;
	assign rep_mode = ~rep_n_s & loop_n_s;

	// clock reference divider
	logic [rpw_pkg::DIV_W-1:0] div_q, div_d;
	logic fast_q, fast_d, ref_q, ref_d;

	always_comb
	begin
		div_d = div_q + 4'h1;
		fast_d = div_d[rpw_pkg::DIV_FAST_BIT];
		ref_d = div_d[rpw_pkg::DIV_REF_BIT];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_q <= '0;
			fast_q <= 1'b0;
			ref_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			fast_q <= fast_d;
			ref_q <= ref_d;
		end
	end

	// cascaded recovery loops
	logic rx_prev_q, rx_prev_d, rx_bit;
	logic speed_prev_q, speed_prev_d;
	logic [15:0] ph1_q, ph1_d, ph2_q, ph2_d, freq_q, freq_d, inc_nom, step;
	logic [15:0] err2;
	logic d1_q, d1_d, rdata_q, rdata_d, rclk_q, rclk_d;
	logic signed [15:0] fcand;

	always_comb
	begin
		rx_bit = loop_mode ? diff_bit(tx_s, tx_n_s, rx_prev_q)
			: diff_bit(rx_line_s, rx_line_n_s, rx_prev_q);
		rx_prev_d = rx_bit;
		speed_prev_d = speed_s;
		inc_nom = speed_s ? rpw_pkg::INC_4M : rpw_pkg::INC_16M;
		step = inc_nom + freq_q;
		ph1_d = ph1_q + step;
		freq_d = freq_q;
		fcand = '0;
		if (rx_bit != rx_prev_q)
		begin
			ph1_d = ph1_q + step - loop_corr(ph1_q, rpw_pkg::LOOP1_SHIFT);
			fcand = $signed(freq_q) - $signed(loop_corr(ph1_q, rpw_pkg::LOOP1_FSHIFT));
			if (fcand > rpw_pkg::FREQ_LIM)
				freq_d = rpw_pkg::FREQ_LIM;
			else if (fcand < -rpw_pkg::FREQ_LIM)
				freq_d = 16'(-rpw_pkg::FREQ_LIM);
			else
				freq_d = fcand;
		end
		d1_d = d1_q;
		if (!ph1_q[15] && ph1_d[15])
			d1_d = rx_bit;
		err2 = ph1_q - ph2_q;
		ph2_d = ph2_q + step + loop_corr(err2, rpw_pkg::LOOP2_SHIFT);
		rclk_d = ph2_d[15];
		rdata_d = rdata_q;
		if (ph2_q[15] && !ph2_d[15])
			rdata_d = d1_q;
		if (speed_s != speed_prev_q)
		begin
			ph1_d = '0;
			ph2_d = '0;
			freq_d = '0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_prev_q <= 1'b0;
			speed_prev_q <= 1'b0;
			ph1_q <= '0;
			ph2_q <= '0;
			freq_q <= '0;
			d1_q <= 1'b0;
			rdata_q <= 1'b0;
			rclk_q <= 1'b0;
		end
		else
		begin
			rx_prev_q <= rx_prev_d;
			speed_prev_q <= speed_prev_d;
			ph1_q <= ph1_d;
			ph2_q <= ph2_d;
			freq_q <= freq_d;
			d1_q <= d1_d;
			rdata_q <= rdata_d;
			rclk_q <= rclk_d;
		end
	end

	// line drive: low in loopback, recovered data in repeat, otherwise transmit pins pass straight through, no sampling
	always_comb
	begin
		if (loop_mode)
		begin
			line_out_p = 1'b0;
			line_out_n = 1'b0;
		end
		else if (rep_mode)
		begin
			line_out_p = rdata_q;
			line_out_n = ~rdata_q;
		end
		else
		begin
			line_out_p = tx_data_in_p;
			line_out_n = tx_data_in_n;
		end
	end

	// phantom drive and watchdog
	logic ins_prev_q, ins_prev_d, ph_on_q, ph_on_d, exp_q, exp_d;
	logic ph_a_q, ph_b_q, wf_n_q, wf_n_d, fault_a, fault_b, exp_clr;
	logic [rpw_pkg::WDT_CNT_W-1:0] wdt_q, wdt_d;
	logic [31:0] ctrl_q, ctrl_d;

	always_comb
	begin
		ins_prev_d = ins_n_s;
		ph_on_d = ph_on_q;
		wdt_d = wdt_q;
		exp_d = exp_q & ~exp_clr;
		if (ins_prev_q && !ins_n_s)
		begin
			ph_on_d = 1'b1;
			wdt_d = '0;
		end
		else if (ins_prev_q != ins_n_s)
			wdt_d = '0;
		else if (ph_on_q)
		begin
			if (wdt_q == rpw_pkg::WDT_CNT_W'(WDT_CYCLES - 1))
			begin
				ph_on_d = 1'b0;
				exp_d = 1'b1;
			end
			else
				wdt_d = wdt_q + 1'b1;
		end
		if (!ctrl_q[rpw_pkg::CTRL_PHANTOM_EN])
			ph_on_d = 1'b0;
		fault_a = hi_a_s | lo_a_s;
		fault_b = hi_b_s | lo_b_s;
		wf_n_d = ~(ph_on_d & (fault_a | fault_b));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ins_prev_q <= 1'b1;
			ph_on_q <= 1'b0;
			wdt_q <= '0;
			exp_q <= 1'b0;
			ph_a_q <= 1'b0;
			ph_b_q <= 1'b0;
			wf_n_q <= 1'b1;
		end
		else
		begin
			ins_prev_q <= ins_prev_d;
			ph_on_q <= ph_on_d;
			wdt_q <= wdt_d;
			exp_q <= exp_d;
			ph_a_q <= ph_on_d;
			ph_b_q <= ph_on_d;
			wf_n_q <= wf_n_d;
		end
	end

	// register slave
	logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_bus_q, rdata_bus_d, status;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic rvalid_q, rvalid_d, do_write;

	always_comb
	begin
		status = '0;
		status[rpw_pkg::ST_LOOPBACK] = loop_mode;
		status[rpw_pkg::ST_REPEAT] = rep_mode;
		status[rpw_pkg::ST_PHANTOM] = ph_on_q;
		status[rpw_pkg::ST_EXPIRED] = exp_q;
		status[rpw_pkg::ST_FAULT_A] = ph_on_q & fault_a;
		status[rpw_pkg::ST_FAULT_B] = ph_on_q & fault_b;
		status[rpw_pkg::ST_SPEED4] = speed_s;
		aw_got_d = aw_got_q | (s_axi_awvalid & s_axi_awready);
		w_got_d = w_got_q | (s_axi_wvalid & s_axi_wready);
		awaddr_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_q;
		wdata_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_q;
		wstrb_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_q;
		do_write = aw_got_q & w_got_q & ~bvalid_q;
		bvalid_d = bvalid_q & ~s_axi_bready;
		bresp_d = bresp_q;
		ctrl_d = ctrl_q;
		exp_clr = 1'b0;
		if (do_write)
		begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = rpw_pkg::RESP_OKAY;
			if (awaddr_q == rpw_pkg::ADDR_CTRL)
			begin
				if (wstrb_q[0])
				begin
					ctrl_d[rpw_pkg::CTRL_PHANTOM_EN] = wdata_q[rpw_pkg::CTRL_PHANTOM_EN];
					exp_clr = wdata_q[rpw_pkg::CTRL_CLR_EXPIRED];
				end
			end
			else if (awaddr_q != rpw_pkg::ADDR_STATUS && awaddr_q != rpw_pkg::ADDR_WDCOUNT)
				bresp_d = rpw_pkg::RESP_SLVERR;
		end
		rvalid_d = rvalid_q & ~s_axi_rready;
		rdata_bus_d = rdata_bus_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid & s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d = rpw_pkg::RESP_OKAY;
			case (s_axi_araddr)
				rpw_pkg::ADDR_CTRL: rdata_bus_d = {31'h0, ctrl_q[rpw_pkg::CTRL_PHANTOM_EN]};
				rpw_pkg::ADDR_STATUS: rdata_bus_d = status;
				rpw_pkg::ADDR_WDCOUNT: rdata_bus_d = 32'(wdt_q);
				default:
				begin
					rdata_bus_d = '0;
					rresp_d = rpw_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= rpw_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_bus_q <= '0;
			rresp_q <= rpw_pkg::RESP_OKAY;
			ctrl_q <= rpw_pkg::CTRL_RESET;
		end
		else
		begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_bus_q <= rdata_bus_d;
			rresp_q <= rresp_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign s_axi_awready = ~aw_got_q & ~bvalid_q;
	assign s_axi_wready = ~w_got_q & ~bvalid_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_bus_q;
	assign s_axi_rresp = rresp_q;
	assign recovered_data = rdata_q;
	assign recovered_clock = rclk_q;
	assign ring_ref_clock = ref_q;
	assign fixed_fast_clock = fast_q;
	assign phantom_out_a = ph_a_q;
	assign phantom_out_b = ph_b_q;
	assign wire_fault_n = wf_n_q;
endmodule : rpw_top
`default_nettype wire

/* verification/rpw_checker_assertions.sv */
// assertion checker on the top-level pins
`timescale 1ns/1ps
`default_nettype none
module rpw_checker #(
	parameter int unsigned WDT_CYCLES = rpw_pkg::WDT_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic loopback_select_n,
	input wire logic repeat_select_n,
	input wire logic tx_data_in_p,
	input wire logic tx_data_in_n,
	input wire logic insert_request_n,
	input wire logic load_high_a,
	input wire logic load_low_a,
	input wire logic load_high_b,
	input wire logic load_low_b,
	input wire logic line_out_p,
	input wire logic line_out_n,
	input wire logic recovered_data,
	input wire logic recovered_clock,
	input wire logic phantom_out_a,
	input wire logic phantom_out_b,
	input wire logic wire_fault_n
);
	logic prev_q;
	logic prev_d;
	int unsigned idle_q;
	int unsigned idle_d;
	logic ld;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	assign ld = load_high_a | load_low_a | load_high_b | load_low_b;
	// cycles since the insertion request last changed
	always_comb
	begin
		prev_d = insert_request_n;
		idle_d = (insert_request_n != prev_q || !aresetn) ? 0 : idle_q + 1;
	end
	always_ff @(posedge aclk)
	begin
		prev_q <= prev_d;
		idle_q <= idle_d;
	end
	a_wrap_low: assert property (
		!loopback_select_n [*7] |-> !line_out_p && !line_out_n) else $error("line not low");
	a_normal_pass: assert property (
		(loopback_select_n && repeat_select_n) [*7]
		|-> line_out_p == tx_data_in_p && line_out_n == tx_data_in_n) else $error("no pass");
	a_repeat_line: assert property (
		(loopback_select_n && !repeat_select_n) [*7]
		|-> line_out_p == recovered_data && line_out_n != recovered_data) else $error("no repeat");
	a_data_on_fall: assert property (
		$changed(recovered_data) |-> $fell(recovered_clock)) else $error("data off clock");
	a_insert_fall: assert property (
		$rose(phantom_out_a) |-> !$past(insert_request_n, 3) && phantom_out_b)
		else $error("bad insertion");
	a_wdt_bound: assert property (
		phantom_out_a |-> idle_q < WDT_CYCLES + 8) else $error("watchdog late");
	a_fault_low: assert property (
		(phantom_out_a && ld) [*6] |-> !wire_fault_n) else $error("fault not shown");
	a_fault_idle: assert property (
		!phantom_out_a [*2] |-> wire_fault_n) else $error("fault while idle");
endmodule : rpw_checker
bind rpw_top rpw_checker #(.WDT_CYCLES(WDT_CYCLES)) u_chk (.*);
`default_nettype wire

/* verification/rpw_proc_model.sv */
// processor-side model: transmit bits, insertion keep-alive, receive sampling
`timescale 1ns/1ps
`default_nettype none
module rpw_proc_model #(
	parameter int unsigned TOG_CYC = 60
) (
	input wire logic aclk,
	input wire logic tx_en,
	input wire logic tog_en,
	input wire logic hold_n,
	input wire logic recovered_clock,
	input wire logic recovered_data,
	output logic tx_data_in_p,
	output logic tx_data_in_n,
	output logic insert_request_n,
	output logic rx_bit,
	output int unsigned rx_seen
);
	logic lclk = 1'b0;
	logic bit_q = 1'b0;
	logic tog_q = 1'b1;
	int unsigned cnt = 0;
	// link clock runs only while sending
	initial
	begin
		#137;
		forever
			#400 lclk = tx_en & ~lclk;
	end
	always @(posedge lclk)
		bit_q <= 1'($urandom_range(1, 0));
	assign tx_data_in_p = tx_en & bit_q;
	assign tx_data_in_n = tx_en & ~bit_q;
	// keep-alive toggle well inside the watchdog window
	always @(posedge aclk)
	begin
		cnt <= (cnt == TOG_CYC - 1) ? 0 : cnt + 1;
		if (tog_en && cnt == TOG_CYC - 1)
			tog_q <= ~tog_q;
	end
	assign insert_request_n = tog_en ? tog_q : hold_n;
	always @(posedge recovered_clock)
	begin
		rx_bit <= recovered_data;
		rx_seen <= rx_seen + 1;
	end
endmodule : rpw_proc_model
`default_nettype wire

/* verification/test_ring_phy_path_and_insertion_watchdog.sv */
// self-checking bench for the ring phy path and insertion watchdog
`timescale 1ns/1ps
`default_nettype none
module test_ring_phy_path_and_insertion_watchdog;
	localparam int unsigned WDT = 200;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [3:0] s_axi_wstrb, ld;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic line_in_p, line_in_n, tx_data_in_p, tx_data_in_n, loopback_select_n, repeat_select_n;
	logic speed_select, insert_request_n, load_high_a, load_low_a, load_high_b, load_low_b;
	logic line_out_p, line_out_n, recovered_data, recovered_clock, ring_ref_clock;
	logic fixed_fast_clock, phantom_out_a, phantom_out_b, wire_fault_n, tx_en, tog_en, hold_n;
	logic rx_bit;
	int unsigned rx_seen, s0;
	int errors, cmp_count, i, n, e, nr, nf, nx;
	assign line_in_p = tx_data_in_p;
	assign line_in_n = tx_data_in_n;
	rpw_top #(.WDT_CYCLES(WDT)) uut (.*);
	rpw_proc_model u_proc (.*);
	function automatic logic [1:0] f_line(input logic [1:0] m, input logic tp, tn, rd);
		if (!m[1])
			return 2'b00;
		return m[0] ? {tp, tn} : {rd, ~rd};
	endfunction : f_line
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task automatic tmo(input logic ok);
		if (ok !== 1'b1)
		begin
			errors++;
			finish_test();
		end
	endtask : tmo
	task automatic cyc(input int c);
		repeat (c) @(posedge aclk);
		#1;
	endtask : cyc
	task automatic wait_ph(input logic v, input int lim);
		for (n = 0; n < lim && phantom_out_a !== v; n++)
			cyc(1);
		tmo(phantom_out_a === v);
	endtask : wait_ph
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		hb = 1'b0;
		for (k = 0; k < 50 && !hb; k++)
		begin
			#1;
			ha = s_axi_awvalid & s_axi_awready;
			hw = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			cyc(1);
			if (ha)
				s_axi_awvalid <= 1'b0;
			if (hw)
				s_axi_wvalid <= 1'b0;
		end
		tmo(hb);
	endtask : axi_wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, x, input logic [1:0] xr);
		logic ha, hr;
		logic [31:0] d;
		int k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		hr = 1'b0;
		for (k = 0; k < 50 && !hr; k++)
		begin
			#1;
			ha = s_axi_arvalid & s_axi_arready;
			hr = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			cyc(1);
			if (ha)
				s_axi_arvalid <= 1'b0;
		end
		tmo(hr);
		check("rdata", d & m, x);
		check("rresp", r, xr);
	endtask : rd_chk
	task automatic count(input int c);
		logic pr, pf, px;
		nr = 0;
		nf = 0;
		nx = 0;
		repeat (c)
		begin
			pr = recovered_clock;
			pf = fixed_fast_clock;
			px = ring_ref_clock;
			cyc(1);
			nr += int'(recovered_clock & ~pr);
			nf += int'(fixed_fast_clock & ~pf);
			nx += int'(ring_ref_clock & ~px);
		end
	endtask : count
	initial
	begin
		aclk = 1'b0;
		forever
			#50 aclk = ~aclk;
	end
	initial
	begin
		errors = 0;
		cmp_count = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_en, tog_en, speed_select, ld} = '0;
		{s_axi_bready, s_axi_rready, loopback_select_n, repeat_select_n, hold_n} = '1;
		{load_high_a, load_low_a, load_high_b, load_low_b} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		void'($urandom(32'h8d3a8a56));
		repeat (16) @(posedge aclk);
		#1;
		aresetn <= 1'b1;
		cyc(4);
		check("idle", {phantom_out_a, phantom_out_b, wire_fault_n}, 3'b001);
		rd_chk(rpw_pkg::ADDR_CTRL, 32'h1, 32'h1, rpw_pkg::RESP_OKAY);
		rd_chk({2'($urandom_range(3, 1)), 6'h0} | 8'h0c, '0, '0, rpw_pkg::RESP_SLVERR);
		axi_wr(8'hfc, $urandom);
		check("bresp", r, rpw_pkg::RESP_SLVERR);
		for (i = 0; i < 2; i++)
		begin
			speed_select <= i[0];
			e = i ? 10 : 40;
			cyc(10);
			count(160);
			check("fast", nf, 40);
			check("ref", nx, 10);
			check("rclk", nr inside {[e - e / 8 - 1 : e + e / 8 + 1]}, 1'b1);
			rd_chk(rpw_pkg::ADDR_STATUS, 32'h40, {25'h0, i[0], 6'h0}, 2'h0);
		end
		tx_en <= 1'b1;
		tog_en <= 1'b1;
		speed_select <= 1'b0;
		wait_ph(1'b1, 200);
		check("ph_b", phantom_out_b, 1'b1);
		for (i = 0; i < 8; i++)
		begin
			ld = (i == 0) ? 4'h0 : 4'($urandom);
			{load_high_a, load_low_a, load_high_b, load_low_b} <= ld;
			cyc(8);
			check("wire_fault_n", wire_fault_n, ~|ld);
			rd_chk(rpw_pkg::ADDR_STATUS, 32'h34, {26'h0, |ld[1:0], |ld[3:2], 4'h4}, 2'h0);
		end
		for (i = 0; i < 4; i++)
		begin
			{loopback_select_n, repeat_select_n} <= i[1:0];
			cyc(8);
			s0 = rx_seen;
			repeat (16)
			begin
				cyc(1);
				check("line", {line_out_p, line_out_n},
					f_line(i[1:0], tx_data_in_p, tx_data_in_n, recovered_data));
				if (recovered_clock === 1'b1)
					check("rx_bit", rx_bit, recovered_data);
			end
			check("rx_run", rx_seen > s0, 1'b1);
			rd_chk(rpw_pkg::ADDR_STATUS, 32'h3, {30'h0, i == 2, !i[1]}, 2'h0);
		end
		ld = 4'hf;
		{load_high_a, load_low_a, load_high_b, load_low_b} <= ld;
		tog_en <= 1'b0;
		cyc(20);
		hold_n <= 1'b0;
		wait_ph(1'b0, WDT + 40);
		check("expiry", n inside {[WDT : WDT + 8]}, 1'b1);
		rd_chk(rpw_pkg::ADDR_STATUS, 32'h8, 32'h8, 2'h0);
		rd_chk(rpw_pkg::ADDR_WDCOUNT, 32'hffffffff, WDT - 1, 2'h0);
		check("off", {phantom_out_b, wire_fault_n}, 2'b01);
		hold_n <= 1'b1;
		cyc(30);
		check("no_rise", phantom_out_a, 1'b0);
		hold_n <= 1'b0;
		wait_ph(1'b1, 12);
		cyc(8);
		check("wire_fault_n_on", wire_fault_n, 1'b0);
		axi_wr(rpw_pkg::ADDR_CTRL, 32'h2);
		cyc(3);
		check("ctrl_off", phantom_out_a, 1'b0);
		check("off_wire_fault_n", {phantom_out_b, wire_fault_n}, 2'b01);
		rd_chk(rpw_pkg::ADDR_STATUS, 32'hc, 32'h0, 2'h0);
		rd_chk(rpw_pkg::ADDR_CTRL, 32'h3, 32'h0, 2'h0);
		finish_test();
	end
endmodule : test_ring_phy_path_and_insertion_watchdog
`default_nettype wire
